// ===== verilog/psd_pkg.sv
// Purpose: Shared constants and carrier types for the page/slot decoder and DRAM sequencer
// Assumes: 125 MHz system clock, active-low CPU strobes
// Notes:   All timing counts derive from times in ns
package psd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int ROW_HOLD_NS     = 16;   // Row address hold after row strobe fall
  localparam int ROW_HOLD_CYC    = (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_NS    = 80;   // Strobe high time between cycles
  localparam int PRECHARGE_CYC   = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_NS      = 15600; // Longest spacing between refresh rows
  localparam int REFRESH_CYC     = REFRESH_NS / CLK_PERIOD_NS;
  localparam int RFSH_RAS_NS     = 120;  // Refresh row strobe low time
  localparam int RFSH_RAS_CYC    = (RFSH_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         PAGE_MSB      = 15;
  localparam int         PAGE_LSB      = 14;
  localparam int         ROW_MSB       = 7;
  localparam int         COL_LSB       = 8;
  localparam int         COL_MSB       = 13;
  localparam int         SLOT_FLD_W    = 2;
  localparam logic [7:0] SLOT_REG_RST  = 8'h00;
  localparam logic [1:0] BASE_SLOT     = 2'h0;
  localparam logic [1:0] PAGE_DRAM_LO  = 2'h2;
  localparam logic [1:0] PAGE_DRAM_HI  = 2'h3;
  localparam logic [7:0] ROW_RST       = 8'h00;
  localparam logic [11:0] CNT_RST      = 12'h000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic        memReqN;
    logic        rdN;
    logic        wrN;
  } psd_cpu_bus_type;

  typedef struct packed {
    logic       rowStrobeN;
    logic       page2ColStrobeN;
    logic       page3ColStrobeN;
    logic       muxSelect;
    logic       writeEnableN;
    logic [7:0] dramAddr;
  } psd_dram_bus_type;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ROW     = 3'b001,
    ST_COL     = 3'b010,
    ST_HOLD    = 3'b011,
    ST_RFSH    = 3'b100,
    ST_PRECHG  = 3'b101
  } psd_state_type;

endpackage : psd_pkg

// ===== verilog/psd_page_slot_dram.sv
// Purpose: Page decode, slot mapping, ROM select and DRAM strobe sequencing
// Assumes: CPU pins are asynchronous and pass a three-flop synchroniser
// Notes:   Refresh is only started between CPU DRAM cycles
`timescale 1ns/1ps

module psd_page_slot_dram #(
  parameter int REFRESH_CYCLES = psd_pkg::REFRESH_CYC
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_b,
  // CPU bus
  input  wire psd_pkg::psd_cpu_bus_type   cpuBus,
  // Slot register
  input  wire logic [7:0]                 slotRegData,
  input  wire logic                       slotRegLoad,
  output logic [7:0]                      slotRegValue,
  // Memory side
  output logic                            program_rom_select_n,
  output logic [14:0]                     romAddr,
  output psd_pkg::psd_dram_bus_type       dramBus,
  output logic [3:1]                      slotSelectN,
  output logic                            refreshBusy
);

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  localparam int BUS_W = $bits(psd_pkg::psd_cpu_bus_type);
  logic [BUS_W-1:0] syncA_reg, syncB_reg, syncC_reg;
  psd_pkg::psd_cpu_bus_type cpuIn_reg;
  logic [BUS_W-1:0] cpuIn_next;

  // Three flops; a bit moves once the second and third agree, so glitches are dropped
  always_ff @(posedge clk_sys) begin
    syncA_reg <= cpuBus;
    syncB_reg <= syncA_reg;
    syncC_reg <= syncB_reg;
  end

  genvar gi;
  generate
    for (gi = 0; gi < BUS_W; gi++) begin : g_agree
      assign cpuIn_next[gi] = (syncB_reg[gi] == syncC_reg[gi]) ? syncC_reg[gi] : cpuIn_reg[gi];
    end
  endgenerate

  // Strobes idle high after reset so no false cycle starts
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cpuIn_reg <= '{addr: 16'h0000, memReqN: 1'b1, rdN: 1'b1, wrN: 1'b1};
    end else begin
      cpuIn_reg <= cpuIn_next;
    end
  end

  // ----------------------------------------------------------------
  // Slot register and page decode
  // ----------------------------------------------------------------
  logic [7:0] slot_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      slot_reg <= psd_pkg::SLOT_REG_RST;
    end else if (slotRegLoad) begin
      slot_reg <= slotRegData;
    end
  end

  // Extract the binary slot number for a page, page 0 in bits 1:0
  function automatic logic [1:0] slotOfPage(input logic [7:0] sr, input logic [1:0] pg);
    slotOfPage = sr[pg*psd_pkg::SLOT_FLD_W +: psd_pkg::SLOT_FLD_W];
  endfunction : slotOfPage

  wire logic [1:0] curPage    = cpuIn_reg.addr[psd_pkg::PAGE_MSB:psd_pkg::PAGE_LSB];
  wire logic [1:0] curSlot    = slotOfPage(slot_reg, curPage);
  wire logic       memActive  = ~cpuIn_reg.memReqN;
  wire logic       baseSel    = memActive && (curSlot == psd_pkg::BASE_SLOT);
  wire logic       isDramPage = (curPage == psd_pkg::PAGE_DRAM_LO) || (curPage == psd_pkg::PAGE_DRAM_HI);
  wire logic       romHit     = baseSel && ~cpuIn_reg.rdN && ~cpuIn_reg.addr[psd_pkg::PAGE_MSB];
  wire logic       dramHit    = baseSel && isDramPage && (~cpuIn_reg.rdN || ~cpuIn_reg.wrN);
  wire logic       bankHi     = cpuIn_reg.addr[psd_pkg::PAGE_LSB];

  // ----------------------------------------------------------------
  // DRAM sequencer
  // ----------------------------------------------------------------
  psd_pkg::psd_state_type state_reg, state_next;
  logic [11:0] cnt_reg, cnt_next;
  logic [11:0] rfshTimer_reg;
  logic        rfshPending_reg;
  logic [7:0]  rfshRow_reg;
  logic        bankHi_reg;
  logic        write_reg;

  wire logic cntDone = (cnt_reg == psd_pkg::CNT_RST);
  wire logic rfshDue = (rfshTimer_reg == 12'(REFRESH_CYCLES - 1));

  // Next state; refresh wins only from idle so a CPU cycle is never cut short
  always_comb begin
    state_next = state_reg;
    cnt_next   = cntDone ? cnt_reg : cnt_reg - 12'h001;
    case (state_reg)
      psd_pkg::ST_IDLE: begin
        if (rfshPending_reg) begin
          state_next = psd_pkg::ST_RFSH;
          cnt_next   = 12'(psd_pkg::RFSH_RAS_CYC - 1);
        end else if (dramHit) begin
          state_next = psd_pkg::ST_ROW;
          cnt_next   = 12'(psd_pkg::ROW_HOLD_CYC - 1);
        end
      end
      psd_pkg::ST_ROW: begin
        if (cntDone) begin
          state_next = psd_pkg::ST_COL;
        end
      end
      psd_pkg::ST_COL: begin
        state_next = psd_pkg::ST_HOLD;
      end
      psd_pkg::ST_HOLD: begin
        if (cpuIn_reg.memReqN) begin
          state_next = psd_pkg::ST_PRECHG;
          cnt_next   = 12'(psd_pkg::PRECHARGE_CYC - 1);
        end
      end
      psd_pkg::ST_RFSH: begin
        if (cntDone) begin
          state_next = psd_pkg::ST_PRECHG;
          cnt_next   = 12'(psd_pkg::PRECHARGE_CYC - 1);
        end
      end
      psd_pkg::ST_PRECHG: begin
        if (cntDone) begin
          state_next = psd_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = psd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg <= psd_pkg::ST_IDLE;
      cnt_reg   <= psd_pkg::CNT_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Capture bank and direction at cycle start; held while strobes are low
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bankHi_reg <= 1'b0;
      write_reg  <= 1'b0;
    end else if (state_reg == psd_pkg::ST_IDLE && state_next == psd_pkg::ST_ROW) begin
      bankHi_reg <= bankHi;
      write_reg  <= ~cpuIn_reg.wrN;
    end
  end

  // Refresh interval timer; the pending flag set wins over the clear
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rfshTimer_reg   <= psd_pkg::CNT_RST;
      rfshPending_reg <= 1'b0;
    end else begin
      rfshTimer_reg   <= rfshDue ? psd_pkg::CNT_RST : rfshTimer_reg + 12'h001;
      rfshPending_reg <= rfshDue || (rfshPending_reg && state_next != psd_pkg::ST_RFSH);
    end
  end

  // Refresh row advances once per refresh, walking all 256 rows
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rfshRow_reg <= psd_pkg::ROW_RST;
    end else if (state_reg == psd_pkg::ST_RFSH && cntDone) begin
      rfshRow_reg <= rfshRow_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  wire logic inRow     = (state_next == psd_pkg::ST_ROW);
  wire logic inCol     = (state_next == psd_pkg::ST_COL) || (state_next == psd_pkg::ST_HOLD);
  wire logic inRfsh    = (state_next == psd_pkg::ST_RFSH);
  wire logic nextBankHi = (state_reg == psd_pkg::ST_IDLE) ? bankHi : bankHi_reg;
  wire logic nextWrite  = (state_reg == psd_pkg::ST_IDLE) ? ~cpuIn_reg.wrN : write_reg;
  // Low group during the row phase, A8..A13 zero-extended in the column phase
  wire logic [7:0] colAddr = {2'b00, cpuIn_reg.addr[psd_pkg::COL_MSB:psd_pkg::COL_LSB]};
  wire logic [7:0] muxAddr = inRfsh ? rfshRow_reg :
                             (inCol ? colAddr : cpuIn_reg.addr[psd_pkg::ROW_MSB:0]);
  // Slot select: one decode of the binary slot number, only slots 1 to 3 leave the chip
  wire logic [3:0] slotOneHot = memActive ? (4'h1 << curSlot) : 4'h0;

  // Strobes, mux select and address registered so they leave the chip glitch free
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dramBus <= '{rowStrobeN: 1'b1, page2ColStrobeN: 1'b1, page3ColStrobeN: 1'b1,
                   muxSelect: 1'b0, writeEnableN: 1'b1, dramAddr: 8'h00};
    end else begin
      dramBus.rowStrobeN      <= ~(inRow || inCol || inRfsh);
      dramBus.muxSelect       <= inCol;
      dramBus.page2ColStrobeN <= ~(inCol && state_reg != psd_pkg::ST_ROW && !nextBankHi);
      dramBus.page3ColStrobeN <= ~(inCol && state_reg != psd_pkg::ST_ROW && nextBankHi);
      dramBus.writeEnableN    <= ~((inRow || inCol) && nextWrite);
      dramBus.dramAddr        <= muxAddr;
    end
  end

  // ROM and slot selects follow the synchronised bus one cycle later
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      program_rom_select_n <= 1'b1;
      romAddr              <= 15'h0000;
      slotSelectN          <= 3'h7;
    end else begin
      program_rom_select_n <= ~romHit;
      romAddr              <= cpuIn_reg.addr[psd_pkg::PAGE_LSB:0];
      slotSelectN          <= ~slotOneHot[3:1];
    end
  end

  assign slotRegValue = slot_reg;
  assign refreshBusy  = (state_reg == psd_pkg::ST_RFSH);

endmodule : psd_page_slot_dram

// ===== dv/psd_mem_model.sv
// Purpose: Memory-side partner that latches what the strobes present
// Assumes: Strobes active low, both 4-bit chips of a bank share strobes
// Notes:   No data pins exist on the controller, so the model only captures
`timescale 1ns/1ps

module psd_mem_model (
  // Strobes and multiplexed address from the controller
  input  wire psd_pkg::psd_dram_bus_type dramBus,
  // Last latched access, for the bench
  output logic [7:0]                     rowSeen,
  output logic [7:0]                     colSeen,
  output logic [1:0]                     bankSeen,
  output logic                           writeSeen,
  output logic [7:0]                     colCount
);
  initial begin
    rowSeen = 8'h00;
    colSeen = 8'h00;
    bankSeen = 2'h0;
    writeSeen = 1'h1;
    colCount = 8'h00;
  end
  // Row latched on the falling row strobe, also during refresh
  always @(negedge dramBus.rowStrobeN) rowSeen = dramBus.dramAddr;
  // One column fall per byte: the chip pair answers as one bank
  task automatic col_fall(input logic [1:0] bank);
    colSeen = dramBus.dramAddr;
    bankSeen = bank;
    writeSeen = dramBus.writeEnableN;
    colCount = colCount + 8'h01;
  endtask : col_fall
  always @(negedge dramBus.page2ColStrobeN) col_fall(2'h2);
  always @(negedge dramBus.page3ColStrobeN) col_fall(2'h3);
endmodule : psd_mem_model

// ===== dv/psd_page_slot_dram_assertions.sv
// Purpose: Port-level checks for the page/slot decoder and DRAM sequencer
// Assumes: CPU pins held steady through each access
// Notes:   Outputs move five edges after a pin change, i.e. four sampled edges back
`timescale 1ns/1ps

module psd_page_slot_dram_assertions #(
  parameter int REFRESH_CYCLES = 64
) (
  // Clock and reset
  input wire logic                      clk_sys,
  input wire logic                      rst_b,
  // Design inputs
  input wire psd_pkg::psd_cpu_bus_type  cpuBus,
  input wire logic [7:0]                slotRegData,
  input wire logic                      slotRegLoad,
  // Design outputs
  input wire logic [7:0]                slotRegValue,
  input wire logic                      program_rom_select_n,
  input wire logic [14:0]               romAddr,
  input wire psd_pkg::psd_dram_bus_type dramBus,
  input wire logic [3:1]                slotSelectN,
  input wire logic                      refreshBusy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Cycles since refresh last ran; a CPU cycle may delay one, hence margin
  logic [15:0] gapCnt_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_b || refreshBusy) gapCnt_reg <= 16'h0000;
    else gapCnt_reg <= gapCnt_reg + 16'h0001;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rom_cause;
    $fell(program_rom_select_n) |-> !$past(cpuBus.memReqN, 4) && !$past(cpuBus.rdN, 4) && !$past(cpuBus.addr[15], 4);
  endproperty
  a_rom_cause: assert property (p_rom_cause) else $error("rom select without read below 8000");
  property p_row_cause;
    $fell(dramBus.rowStrobeN) && !refreshBusy |-> $past(cpuBus.addr[15], 4) && !$past(cpuBus.memReqN, 4);
  endproperty
  a_row_cause: assert property (p_row_cause) else $error("row strobe outside dram pages");
  property p_row_mux;
    $fell(dramBus.rowStrobeN) |-> !dramBus.muxSelect;
  endproperty
  a_row_mux: assert property (p_row_mux) else $error("row strobe with column group");
  property p_mux_late;
    $rose(dramBus.muxSelect) |-> !$past(dramBus.rowStrobeN, 2) && dramBus.dramAddr[7:6] == 2'h0;
  endproperty
  a_mux_late: assert property (p_mux_late) else $error("mux switched too early");
  property p_col_next;
    $rose(dramBus.muxSelect) |=> dramBus.page2ColStrobeN != dramBus.page3ColStrobeN;
  endproperty
  a_col_next: assert property (p_col_next) else $error("column strobe missing");
  property p_col_ok;
    !(dramBus.page2ColStrobeN && dramBus.page3ColStrobeN) |->
      dramBus.muxSelect && !dramBus.rowStrobeN && dramBus.page2ColStrobeN != dramBus.page3ColStrobeN;
  endproperty
  a_col_ok: assert property (p_col_ok) else $error("bad column strobe state");
  property p_slot_load;
    slotRegLoad |=> slotRegValue == $past(slotRegData);
  endproperty
  a_slot_load: assert property (p_slot_load) else $error("slot register load lost");
  property p_reset;
    disable iff (1'b0) !rst_b |=> slotRegValue == 8'h00 && slotSelectN == 3'h7 && program_rom_select_n;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_one_slot;
    $onehot0(~slotSelectN);
  endproperty
  a_one_slot: assert property (p_one_slot) else $error("two slot selects low");
  property p_rfsh_len;
    $rose(refreshBusy) |-> (refreshBusy && dramBus.page2ColStrobeN && dramBus.page3ColStrobeN)[*8];
  endproperty
  a_rfsh_len: assert property (p_rfsh_len) else $error("refresh too short or with column");
  property p_rfsh_gap;
    gapCnt_reg < 16'(REFRESH_CYCLES + 128);
  endproperty
  a_rfsh_gap: assert property (p_rfsh_gap) else $error("refresh overdue");
  c_bank2: cover property (!dramBus.page2ColStrobeN);
  c_bank3: cover property (!dramBus.page3ColStrobeN);
  c_slot: cover property (slotSelectN != 3'h7);
endmodule : psd_page_slot_dram_assertions

// ===== dv/psd_page_slot_dram_tb.sv
// Purpose: Self-checking bench for the page/slot decoder
// Assumes: Inputs driven 1 ns after the rising edge
// Notes:   Refresh interval shortened to keep the run brief
`timescale 1ns/1ps

module psd_page_slot_dram_tb;
  typedef struct packed {
    logic [7:0] slot; logic [15:0] addr; logic rdN; logic wrN;
    logic romN; logic [2:0] slotN; logic [1:0] bank;
  } psd_row_type;
  localparam int RFSH = 64;
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  psd_pkg::psd_cpu_bus_type cpuBus = '{16'h0000, 1'h1, 1'h1, 1'h1};
  logic [7:0] slotRegData = 8'h00;
  logic slotRegLoad = 1'h0;
  logic [7:0] slotRegValue, rowSeen, colSeen, colCount;
  logic program_rom_select_n, refreshBusy, writeSeen;
  logic [14:0] romAddr;
  psd_pkg::psd_dram_bus_type dramBus;
  logic [3:1] slotSelectN;
  logic [1:0] bankSeen;
  int error_cnt = 0;
  int num_checks = 0;
  int rfshCnt = 0;
  int n;
  // Slot, address, strobes, then expected ROM select, slot selects, bank
  psd_row_type rows[12] = '{
    '{8'h00, 16'h0000, 1'h0, 1'h1, 1'h0, 3'h7, 2'h0}, '{8'h00, 16'h7FFF, 1'h0, 1'h1, 1'h0, 3'h7, 2'h0},
    '{8'h00, 16'h8000, 1'h0, 1'h1, 1'h1, 3'h7, 2'h2}, '{8'h00, 16'hBFFF, 1'h1, 1'h0, 1'h1, 3'h7, 2'h2},
    '{8'h00, 16'hC000, 1'h0, 1'h1, 1'h1, 3'h7, 2'h3}, '{8'h00, 16'hFFFF, 1'h1, 1'h0, 1'h1, 3'h7, 2'h3},
    '{8'h04, 16'h4000, 1'h0, 1'h1, 1'h1, 3'h6, 2'h0}, '{8'h04, 16'h0123, 1'h0, 1'h1, 1'h0, 3'h7, 2'h0},
    '{8'h80, 16'hC5A5, 1'h0, 1'h1, 1'h1, 3'h5, 2'h0}, '{8'hC0, 16'hC000, 1'h1, 1'h0, 1'h1, 3'h3, 2'h0},
    '{8'h30, 16'h8123, 1'h0, 1'h1, 1'h1, 3'h3, 2'h0}, '{8'h00, 16'h0123, 1'h1, 1'h0, 1'h1, 3'h7, 2'h0}};
  always #4 clk_sys = ~clk_sys;
  always @(posedge refreshBusy) rfshCnt++;
  psd_page_slot_dram #(.REFRESH_CYCLES(RFSH)) psd_page_slot_dram_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .cpuBus(cpuBus), .slotRegData(slotRegData), .slotRegLoad(slotRegLoad), .slotRegValue(slotRegValue),
    .program_rom_select_n(program_rom_select_n), .romAddr(romAddr), .dramBus(dramBus),
    .slotSelectN(slotSelectN), .refreshBusy(refreshBusy));
  psd_mem_model psd_mem_model_inst (.dramBus(dramBus), .rowSeen(rowSeen), .colSeen(colSeen),
    .bankSeen(bankSeen), .writeSeen(writeSeen), .colCount(colCount));
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic load(input logic [7:0] v);
    slotRegData = v;
    slotRegLoad = 1'h1;
    step(1);
    slotRegLoad = 1'h0;
    step(1);
    chk("slotRegValue", 16'(v), 16'(slotRegValue));
  endtask : load
  // One access: DRAM rows wait for the column strobe, a refresh may delay it
  task automatic access(input psd_row_type r);
    logic [7:0] c0;
    load(r.slot);
    c0 = colCount;
    cpuBus = '{r.addr, 1'h0, r.rdN, r.wrN};
    if (r.bank != 2'h0) begin
      for (int k = 0; k < 60 && dramBus.page2ColStrobeN && dramBus.page3ColStrobeN; k++) step(1);
      chk("rowSeen", 16'(r.addr[7:0]), 16'(rowSeen));
      chk("colSeen", 16'(r.addr[13:8]), 16'(colSeen));
      chk("bankSeen", 16'(r.bank), 16'(bankSeen));
      chk("writeSeen", 16'(r.wrN), 16'(writeSeen));
    end else step(8);
    chk("romSelect", 16'(r.romN), 16'(program_rom_select_n));
    chk("slotSelectN", 16'(r.slotN), 16'(slotSelectN));
    chk("romAddr", 16'(r.addr[14:0]), 16'(romAddr));
    if (r.bank == 2'h0) chk("colCount", 16'(c0), 16'(colCount));
    cpuBus = '{r.addr, 1'h1, 1'h1, 1'h1};
    step(16);
    chk("romIdle", 16'h1, 16'(program_rom_select_n));
  endtask : access
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // Watchdog sized well beyond the expected run of under a thousand cycles
  initial begin
    #(20000 * 8);
    error_cnt++;
    print_verdict();
  end
  initial begin
    step(8);
    rst_b = 1'h1;
    step(4);
    foreach (rows[i]) begin
      access(rows[i]);
      $display("row test %0d done", i);
    end
    // Mid-run reset with every page mapped away from the base slot
    load(8'hFF);
    rst_b = 1'h0;
    step(8);
    chk("slotRegValue", 16'h0000, 16'(slotRegValue));
    chk("slotSelectN", 16'h0007, 16'(slotSelectN));
    chk("rowStrobeN", 16'h0001, 16'(dramBus.rowStrobeN));
    rst_b = 1'h1;
    cpuBus = '{16'h1234, 1'h0, 1'h0, 1'h1};
    step(8);
    chk("romAfterReset", 16'h0000, 16'(program_rom_select_n));
    cpuBus = '{16'h1234, 1'h1, 1'h1, 1'h1};
    $display("reset test done");
    // Idle stretch: refresh must keep coming on its own
    n = rfshCnt;
    step(4 * RFSH);
    chk("refreshRuns", 16'h0001, 16'((rfshCnt - n) >= 3));
    $display("refresh test done");
    print_verdict();
  end
endmodule : psd_page_slot_dram_tb

bind psd_page_slot_dram psd_page_slot_dram_assertions #(.REFRESH_CYCLES(REFRESH_CYCLES)) psd_chk_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .cpuBus(cpuBus), .slotRegData(slotRegData), .slotRegLoad(slotRegLoad),
  .slotRegValue(slotRegValue), .program_rom_select_n(program_rom_select_n), .romAddr(romAddr),
  .dramBus(dramBus), .slotSelectN(slotSelectN), .refreshBusy(refreshBusy));
